//--- rtl/dmacm_channel.sv
module dmacm_channel (
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_enable,
  input  wire logic        i_request,
  input  wire logic        i_load,
  input  wire logic [31:0] i_ctrl_word,
  input  wire logic        i_item_done,
  output logic             o_item_go,
  output logic             o_use_alt,
  output logic [9:0]       o_items_left,
  output logic [2:0]       o_mode,
  output logic             o_active,
  output logic             o_cycle_done,
  output logic             o_bad_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // channel states and the way a mode paces its items
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_RUN
  } dmacm_state_e;

  typedef enum logic [1:0] {
    KIND_STOP,
    KIND_STEP,
    KIND_FREE,
    KIND_SWAP
  } dmacm_kind_e;

  ////////////////////////////////////////////////////////////////////////////
  // how a mode paces its items once the channel runs
  function automatic dmacm_kind_e dmacm_mode_kind(input logic [2:0] m);
    dmacm_kind_e k;
    k = KIND_STOP;
    unique case (m)
      dmacm_pkg::MODE_STOP: begin
        k = KIND_STOP;
      end
      dmacm_pkg::MODE_BASIC: begin
        k = KIND_STEP;
      end
      dmacm_pkg::MODE_AUTO: begin
        k = KIND_FREE;
      end
      dmacm_pkg::MODE_PINGPONG: begin
        k = KIND_SWAP;
      end
      // scatter-gather paces like auto-request; its sequencing lives elsewhere
      dmacm_pkg::MODE_MSG_PRI,
      dmacm_pkg::MODE_MSG_ALT,
      dmacm_pkg::MODE_PSG_PRI,
      dmacm_pkg::MODE_PSG_ALT: begin
        k = KIND_FREE;
      end
    endcase
    return k;
  endfunction : dmacm_mode_kind

  ////////////////////////////////////////////////////////////////////////////
  // a mode is legal only in the structure that may hold it
  function automatic logic dmacm_mode_ok(input logic [2:0] m, input logic alt);
    logic ok;
    ok = 1'b1;
    unique case (m)
      dmacm_pkg::MODE_STOP: begin
        ok = 1'b0;
      end
      dmacm_pkg::MODE_BASIC: begin
        ok = 1'b1;
      end
      dmacm_pkg::MODE_AUTO: begin
        ok = 1'b1;
      end
      dmacm_pkg::MODE_PINGPONG: begin
        ok = 1'b1;
      end
      dmacm_pkg::MODE_MSG_PRI: begin
        ok = !alt;
      end
      dmacm_pkg::MODE_MSG_ALT: begin
        ok = alt;
      end
      dmacm_pkg::MODE_PSG_PRI: begin
        ok = !alt;
      end
      dmacm_pkg::MODE_PSG_ALT: begin
        ok = alt;
      end
    endcase
    return ok;
  endfunction : dmacm_mode_ok

  ////////////////////////////////////////////////////////////////////////////
  dmacm_state_e st_r;
  dmacm_state_e st_nxt;
  logic [2:0]   mode_r;
  logic [2:0]   mode_nxt;
  logic [9:0]   cnt_r;
  logic [9:0]   cnt_nxt;
  logic         alt_r;
  logic         alt_nxt;
  logic         go_r;
  logic         go_nxt;
  logic         done_r;
  logic         done_nxt;
  logic         bad_r;
  logic         bad_nxt;
  logic         act_r;
  logic         act_nxt;
  logic [2:0]   ld_mode;
  logic [9:0]   ld_cnt;
  logic         ld_take;
  logic         ld_ok;
  logic         last_item;
  logic         pp_rewrite;
  dmacm_kind_e  run_kind;

  assign ld_mode    = i_ctrl_word[dmacm_pkg::MODE_LSB +: dmacm_pkg::MODE_W];
  assign ld_cnt     = i_ctrl_word[dmacm_pkg::CNT_LSB +: dmacm_pkg::CNT_W];
  assign ld_take    = i_load && i_enable;
  assign ld_ok      = dmacm_mode_ok(ld_mode, alt_r);
  assign last_item  = (cnt_r == dmacm_pkg::CNT_RST);
  assign run_kind   = dmacm_mode_kind(mode_r);
  assign pp_rewrite = ld_take && (st_r != ST_IDLE) && (mode_r == dmacm_pkg::MODE_PINGPONG) &&
                      ((ld_mode == dmacm_pkg::MODE_BASIC) || (ld_mode == dmacm_pkg::MODE_AUTO));

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic of the channel
  always_comb begin
    st_nxt   = st_r;
    mode_nxt = mode_r;
    cnt_nxt  = cnt_r;
    alt_nxt  = alt_r;
    go_nxt   = 1'b0;
    done_nxt = 1'b0;
    bad_nxt  = bad_r;
    unique case (st_r)
      ST_IDLE: begin
        // the stored word resets to MODE_STOP, so only an explicit load arms the channel
        if (ld_take) begin
          mode_nxt = ld_mode;
          cnt_nxt  = ld_cnt;
          bad_nxt  = !ld_ok;
          if (ld_ok) begin
            st_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (!i_enable) begin
          st_nxt = ST_IDLE;
        end else if (i_request) begin
          st_nxt = ST_RUN;
          go_nxt = 1'b1;
        end
      end
      ST_RUN: begin
        if (i_item_done) begin
          if (last_item) begin
            done_nxt = 1'b1;
            mode_nxt = dmacm_pkg::MODE_STOP;
            st_nxt   = ST_IDLE;
            if (run_kind == KIND_SWAP) begin
              alt_nxt = !alt_r;
            end
          end else begin
            cnt_nxt = cnt_r - 10'h001;
            if (run_kind == KIND_STEP) begin
              st_nxt = ST_WAIT;
            end else begin
              go_nxt = 1'b1;
            end
          end
        end
      end
    endcase
    // a rewrite ends the alternation; a cycle ending on the same edge still stops
    if (pp_rewrite && !done_nxt) begin
      mode_nxt = ld_mode;
    end
    act_nxt = (st_nxt != ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r   <= ST_IDLE;
      mode_r <= dmacm_pkg::MODE_STOP;
      cnt_r  <= dmacm_pkg::CNT_RST;
      alt_r  <= dmacm_pkg::ALT_RST;
      go_r   <= 1'b0;
      done_r <= 1'b0;
      bad_r  <= 1'b0;
      act_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      mode_r <= mode_nxt;
      cnt_r  <= cnt_nxt;
      alt_r  <= alt_nxt;
      go_r   <= go_nxt;
      done_r <= done_nxt;
      bad_r  <= bad_nxt;
      act_r  <= act_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_item_go    = go_r;
  assign o_use_alt    = alt_r;
  assign o_items_left = cnt_r;
  assign o_mode       = mode_r;
  assign o_active     = act_r;
  assign o_cycle_done = done_r;
  assign o_bad_mode   = bad_r;

endmodule : dmacm_channel

//--- rtl/dmacm_pkg.sv
package dmacm_pkg;

  // control word field layout
  localparam int MODE_LSB = 0;
  localparam int MODE_W   = 3;
  localparam int CNT_LSB  = 4;
  localparam int CNT_W    = 10;
  localparam int WORD_W   = 32;

  // cycle_mode_field encodings
  localparam logic [2:0] MODE_STOP    = 3'h0;
  localparam logic [2:0] MODE_BASIC   = 3'h1;
  localparam logic [2:0] MODE_AUTO    = 3'h2;
  localparam logic [2:0] MODE_PINGPONG = 3'h3;
  localparam logic [2:0] MODE_MSG_PRI = 3'h4;
  localparam logic [2:0] MODE_MSG_ALT = 3'h5;
  localparam logic [2:0] MODE_PSG_PRI = 3'h6;
  localparam logic [2:0] MODE_PSG_ALT = 3'h7;

  // reset values
  localparam logic [9:0] CNT_RST  = 10'h000;
  localparam logic       ALT_RST  = 1'b0;

endpackage : dmacm_pkg

//--- tb/dmacm_channel_monitor.sv
module dmacm_channel_monitor (
  input wire logic        i_mclk, i_nrst, i_enable, i_request, i_load, i_item_done,
  input wire logic [31:0] i_ctrl_word,
  input wire logic        o_item_go, o_use_alt, o_active, o_cycle_done, o_bad_mode,
  input wire logic [9:0]  o_items_left,
  input wire logic [2:0]  o_mode
);
  wire [2:0] m  = i_ctrl_word[2:0];
  wire       ld = i_load && i_enable;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  a_load_mode: assert property (ld && !o_active && !m[2] && |m |=> o_mode == $past(m)) else $error("mode");
  a_stop_quiet: assert property (o_mode == 3'h0 |-> !o_item_go) else $error("stop");
  a_basic_req: assert property (o_item_go && o_mode == 3'h1 |-> $past(i_request)) else $error("req");
  a_auto_next: assert property (o_mode == 3'h2 && i_item_done && |o_items_left |=> o_item_go) else $error("auto");
  a_pp_toggle: assert property (o_cycle_done && $past(o_mode) == 3'h3 |-> o_use_alt != $past(o_use_alt))
    else $error("alt");
  a_pp_end: assert property (ld && o_active && o_mode == 3'h3 && m inside {3'h1, 3'h2} |=> o_mode == $past(m))
    else $error("pp end");
  a_sg_place: assert property (ld && !o_active && m[2] && m[0] != o_use_alt |=> o_bad_mode && !o_active)
    else $error("sg");
  a_last_done: assert property (o_active && i_item_done && o_items_left == 10'h0 |=> o_cycle_done && o_mode == 3'h0)
    else $error("last");
endmodule : dmacm_channel_monitor
bind dmacm_channel dmacm_channel_monitor u_dmacm_channel_monitor (.*);

//--- tb/dmacm_channel_tb_top.sv
module dmacm_channel_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, nrst = 1'b0, en = 1'b0, req = 1'b0, load = 1'b0, slow = 1'b0;
  logic [31:0] word = 32'h0;
  logic        done_i, go, alt, act, done, bad;
  logic [9:0]  left;
  logic [2:0]  mode;
  int          n_errors = 0, samples_checked = 0, n_go = 0, cyc = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) n_go <= n_go + go;
  always @(posedge clk) if (++cyc == 3000) begin
    n_errors++;
    conclude();
  end
  dmacm_channel u_dmacm_channel (.i_mclk(clk), .i_nrst(nrst), .i_enable(en), .i_request(req), .i_load(load),
    .i_ctrl_word(word), .i_item_done(done_i), .o_item_go(go), .o_use_alt(alt), .o_items_left(left),
    .o_mode(mode), .o_active(act), .o_cycle_done(done), .o_bad_mode(bad));
  dmacm_engine u_dmacm_engine (.i_mclk(clk), .i_nrst(nrst), .i_go(go), .i_slow(slow), .o_done(done_i));
  ////////////////////////////////
  task automatic chk(input string nm, input logic [9:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic ld(input logic [2:0] m, input logic [9:0] c);
    word = {18'h0, c, 1'b0, m};
    load = 1'b1;
    @(negedge clk) load = 1'b0;
  endtask : ld
  task automatic rq;
    req = 1'b1;
    @(negedge clk) req = 1'b0;
  endtask : rq
  task automatic run(input int n);
    n_go = 0;
    rq();
    for (int k = 0; k < 60 && done !== 1'b1; k++) @(negedge clk);
    chk("done", done, 1'b1);
    chk("items", 10'(n_go), 10'(n));
  endtask : run
  ////////////////////////////////
  task automatic t_main;
    logic [2:0] bm [3] = '{3'h0, 3'h5, 3'h7};
    ld(3'h2, 10'h3);
    chk("mode", mode, 3'h2);
    chk("left", left, 10'h3);
    run(4);
    chk("stop", mode, 3'h0);
    ld(3'h1, 10'h1);
    n_go = 0;
    rq();
    repeat (6) @(negedge clk);
    chk("wait", 10'(n_go), 10'h1);
    run(1);
    ld(3'h3, 10'h0);
    run(1);
    chk("alt", alt, 1'b1);
    ld(3'h3, 10'h0);
    run(1);
    chk("alt", alt, 1'b0);
    slow = 1'b1;
    ld(3'h3, 10'h1);
    rq();
    ld(3'h1, 10'h1);
    chk("end", mode, 3'h1);
    nrst = 1'b0;
    @(negedge clk) nrst = 1'b1;
    slow = 1'b0;
    foreach (bm[i]) begin
      ld(bm[i], 10'h0);
      chk("bad", bad, 1'b1);
      chk("idle", act, 1'b0);
    end
    ld(3'h4, 10'h0);
    chk("sg", bad, 1'b0);
    run(1);
    $display("test main done");
  endtask : t_main
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    en = 1'b1;
    t_main();
    conclude();
  end
endmodule : dmacm_channel_tb_top

//--- tb/dmacm_engine.sv
module dmacm_engine (
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  input  wire logic i_go,
  input  wire logic i_slow,
  output logic      o_done = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] wait_r = 3'h0;
  // slow items leave room for a rewrite mid-cycle
  // reset is taken at once so a reset on a falling edge cannot race the countdown
  always @(negedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_done <= 1'b0;
      wait_r <= 3'h0;
    end else begin
      o_done <= (wait_r == 3'h1);
      if (i_go) wait_r <= i_slow ? 3'h4 : 3'h1;
      else if (wait_r != 3'h0) wait_r <= wait_r - 3'h1;
    end
  end
endmodule : dmacm_engine
